// File: hdl/bitrev_agu_pkg.sv
// shared types and constants for the bit-reversed write address generator
package bitrev_agu_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// register byte offsets
	localparam logic [7:0] OFS_BIT_REVERSE_CONTROL = 8'h00;
	localparam logic [7:0] OFS_ADDRESSING_MODE_CONTROL = 8'h04;
	localparam logic [7:0] OFS_MODULO_START = 8'h08;
	localparam logic [7:0] OFS_MODULO_END = 8'h0C;
	localparam logic [7:0] OFS_LAST_WRITE_EA = 8'h10;
	// bit_reverse_control fields
	localparam int REVERSAL_ENABLE_BIT = 15;
	localparam int REVERSAL_PIVOT_MSB = 14;
	// addressing_mode_control fields
	localparam int MODULO_ENABLE_BIT = 15;
	localparam int WRITE_POINTER_SELECT_LSB = 8;
	localparam int MODULO_POINTER_LSB = 0;
	localparam logic [3:0] STACK_POINTER_NUM = 4'hF;
	// reset values
	localparam logic [15:0] BIT_REVERSE_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] ADDRESSING_MODE_CONTROL_RESET = 16'h0F0F;
	localparam logic [15:0] MODULO_START_RESET = 16'h0000;
	localparam logic [15:0] MODULO_END_RESET = 16'hFFFF;
	localparam logic [15:0] LAST_WRITE_EA_RESET = 16'h0000;
	// address step per access size
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] BYTE_STEP = 16'h0001;

	typedef enum logic [2:0] {
		AM_INDIRECT,
		AM_POST_INC,
		AM_PRE_INC,
		AM_POST_DEC,
		AM_PRE_DEC,
		AM_REG_OFFSET
	} addr_mode_t;

	typedef struct packed {
		logic valid;
		logic isByte;
		addr_mode_t mode;
		logic [3:0] regNum;
		logic [15:0] pointer;
		logic [15:0] offset;
	} agu_req_t;

	typedef struct packed {
		logic valid;
		logic [15:0] ea;
		logic writeBack;
		logic [3:0] wbRegNum;
		logic [15:0] wbValue;
		logic reversed;
	} agu_resp_t;
endpackage : bitrev_agu_pkg

// File: hdl/reverse_carry_adder.sv
// adder whose carries run from the top bit toward bit zero
`timescale 1ns/1ps
`default_nettype none
module reverse_carry_adder (
	input wire logic [15:0] base,
	input wire logic [15:0] modifier,
	output logic [15:0] sum
);
	function automatic logic [15:0] mirror(input logic [15:0] v);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++)
		begin
			m[i] = v[15 - i];
		end
		return m;
	endfunction : mirror

	logic [15:0] mirrored;

	// mirror, add, mirror back
	assign mirrored = 16'(mirror(base) + mirror(modifier));
	assign sum = mirror(mirrored);
endmodule : reverse_carry_adder
`default_nettype wire

// File: hdl/modulo_corrector.sv
// circular buffer boundary correction for one address generator
`timescale 1ns/1ps
`default_nettype none
module modulo_corrector (
	input wire logic [15:0] addr,
	input wire logic [15:0] startAddr,
	input wire logic [15:0] endAddr,
	input wire logic upward,
	output logic [15:0] corrected,
	output logic wrapped
);
	logic [15:0] length;

	assign length = 16'(endAddr - startAddr + 16'h0001);

	// boundaries are compared by magnitude, so jumps past them still wrap
	always_comb
	begin
		corrected = addr;
		wrapped = 1'b0;
		if (upward && (addr > endAddr))
		begin
			corrected = 16'(addr - length);
			wrapped = 1'b1;
		end
		else if (!upward && (addr < startAddr))
		begin
			corrected = 16'(addr + length);
			wrapped = 1'b1;
		end
	end
endmodule : modulo_corrector
`default_nettype wire

// File: hdl/bit_reversed_write_agu.sv
// X address generators with bit-reversed write addressing
// Behaviour
// R1: reversed addressing only in the write generator, never for reads
// R2: modifier treated as bit-reversed; pointer and result stay normal order
// R3: enabled when pointer select not 15, enable set, pre/post increment
// R4: software aligns a 2^N byte buffer to have N low zero bits
// R5: pivot modifier comes from control register bits 14 down to 0
// R6: word-sized data assumed; modifier scaled by two to byte addresses
// R7: byte access or other mode while enabled gives a normal address
// R8: pointer plus modifier; the usual increment is ignored
// R9: effective address bit zero is always zero when reversed
// R10: reversal beats modulo in write generator; reads keep modulo
// R11: control register bit 15 enables reversed addressing
// R12: software avoids indirect read via pointer right after control write
// R13: write back only for pre/post modify, never for register offset
// R14: next address adds modifier with carries from top toward bit zero
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module bit_reversed_write_agu
	import bitrev_agu_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [bitrev_agu_pkg::ADDR_W-1:0] regAddr,
	input wire logic [bitrev_agu_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [bitrev_agu_pkg::DATA_W-1:0] regRdData,
	input wire bitrev_agu_pkg::agu_req_t wrReq,
	input wire bitrev_agu_pkg::agu_req_t rdReq,
	output bitrev_agu_pkg::agu_resp_t wrResp,
	output bitrev_agu_pkg::agu_resp_t rdResp
);
	import bitrev_agu_pkg::*;

	typedef struct packed {
		logic [15:0] bitReverseControl;
		logic [15:0] addressingModeControl;
		logic [15:0] moduloStart;
		logic [15:0] moduloEnd;
		logic [15:0] lastWriteEa;
		logic [15:0] rdData;
		agu_resp_t wrResp;
		agu_resp_t rdResp;
	} state_t;

	localparam state_t STATE_RESET = '{
		bitReverseControl: BIT_REVERSE_CONTROL_RESET,
		addressingModeControl: ADDRESSING_MODE_CONTROL_RESET,
		moduloStart: MODULO_START_RESET,
		moduloEnd: MODULO_END_RESET,
		lastWriteEa: LAST_WRITE_EA_RESET,
		rdData: 16'h0000,
		wrResp: '0,
		rdResp: '0
	};

	// step of an access of the given size
	function automatic logic [15:0] stepOf(input agu_req_t r);
		return r.isByte ? BYTE_STEP : WORD_STEP;
	endfunction : stepOf

	// pointer value after the modification that the mode asks for
	function automatic logic [15:0] rawNext(input agu_req_t r);
		logic [15:0] n;
		n = r.pointer;
		unique case (r.mode)
			AM_POST_INC, AM_PRE_INC: n = 16'(r.pointer + stepOf(r));
			AM_POST_DEC, AM_PRE_DEC: n = 16'(r.pointer - stepOf(r));
			AM_REG_OFFSET: n = 16'(r.pointer + r.offset);
			AM_INDIRECT: n = r.pointer;
			// released requests may carry unused codes
			default: n = r.pointer;
		endcase
		return n;
	endfunction : rawNext

	// the address moves upward for increments and positive offsets
	function automatic logic goesUp(input agu_req_t r);
		return (r.mode == AM_POST_INC) || (r.mode == AM_PRE_INC)
			|| ((r.mode == AM_REG_OFFSET) && !r.offset[15]);
	endfunction : goesUp

	// normal response from the pointer and a possibly corrected address
	function automatic agu_resp_t normalResp(input agu_req_t r,
		input logic [15:0] nextAddr);
		agu_resp_t p;
		p = '0;
		p.valid = r.valid;
		p.wbRegNum = r.regNum;
		p.wbValue = nextAddr;
		unique case (r.mode)
			AM_PRE_INC, AM_PRE_DEC:
			begin
				p.ea = nextAddr;
				p.writeBack = r.valid;
			end
			AM_POST_INC, AM_POST_DEC:
			begin
				p.ea = r.pointer;
				p.writeBack = r.valid;
			end
			AM_REG_OFFSET:
			begin
				p.ea = nextAddr;
				p.writeBack = 1'b0; // R13
			end
			AM_INDIRECT:
			begin
				p.ea = r.pointer;
				p.writeBack = 1'b0;
			end
			// unused codes give an address with no write-back
			default: p.ea = r.pointer;
		endcase
		return p;
	endfunction : normalResp

	logic [1:0] rstSync_r;
	logic rstN;
	state_t state_r;
	state_t state_nxt;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstSync_r <= 2'b00;
		end
		else
		begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end

	assign rstN = rstSync_r[1];

	logic reversalEnable;
	logic [14:0] reversalPivot;
	logic [3:0] writePointerSelect;
	logic [3:0] moduloPointer;
	logic moduloEnable;
	logic [15:0] scaledModifier;
	logic [15:0] revSum;
	logic revCond;
	logic wrRawUp;
	logic rdRawUp;
	logic [15:0] wrRaw;
	logic [15:0] rdRaw;
	logic [15:0] wrCorr;
	logic [15:0] rdCorr;
	logic wrModHit;
	logic rdModHit;
	logic [15:0] wrNext;
	logic [15:0] rdNext;
	addr_mode_t wrMode;
	addr_mode_t rdMode;
	logic wrIsByte;
	logic [15:0] wrPointer;

	assign reversalEnable = state_r.bitReverseControl[REVERSAL_ENABLE_BIT]; // R11
	assign reversalPivot = state_r.bitReverseControl[REVERSAL_PIVOT_MSB:0]; // R5
	assign writePointerSelect =
		state_r.addressingModeControl[WRITE_POINTER_SELECT_LSB+:4];
	assign moduloPointer = state_r.addressingModeControl[MODULO_POINTER_LSB+:4];
	assign moduloEnable = state_r.addressingModeControl[MODULO_ENABLE_BIT];
	assign wrMode = wrReq.mode;
	assign rdMode = rdReq.mode;
	assign wrIsByte = wrReq.isByte;
	assign wrPointer = wrReq.pointer;

	// pivot counts words, so it is doubled to a byte modifier
	assign scaledModifier = {reversalPivot, 1'b0}; // R6

	// only the write generator may reverse, and only word writes via the pointer
	assign revCond = wrReq.valid && reversalEnable // R1 R11
		&& (writePointerSelect != STACK_POINTER_NUM) // R3
		&& (wrReq.regNum == writePointerSelect)
		&& ((wrReq.mode == AM_PRE_INC) || (wrReq.mode == AM_POST_INC)) // R3
		&& !wrReq.isByte; // R7

	reverse_carry_adder u_revAdder (
		.base(wrReq.pointer),
		.modifier(scaledModifier),
		.sum(revSum)
	); // R2 R14

	assign wrRaw = rawNext(wrReq);
	assign rdRaw = rawNext(rdReq);
	assign wrRawUp = goesUp(wrReq);
	assign rdRawUp = goesUp(rdReq);

	modulo_corrector u_wrModulo (
		.addr(wrRaw),
		.startAddr(state_r.moduloStart),
		.endAddr(state_r.moduloEnd),
		.upward(wrRawUp),
		.corrected(wrCorr),
		.wrapped()
	);

	modulo_corrector u_rdModulo (
		.addr(rdRaw),
		.startAddr(state_r.moduloStart),
		.endAddr(state_r.moduloEnd),
		.upward(rdRawUp),
		.corrected(rdCorr),
		.wrapped()
	);

	// reversal switches write-side modulo off; read side keeps it
	assign wrModHit = moduloEnable && !revCond // R10
		&& (wrReq.regNum == moduloPointer) && (wrReq.mode != AM_INDIRECT);
	assign rdModHit = moduloEnable // R10
		&& (rdReq.regNum == moduloPointer) && (rdReq.mode != AM_INDIRECT);
	assign wrNext = wrModHit ? wrCorr : wrRaw;
	assign rdNext = rdModHit ? rdCorr : rdRaw;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.rdData = 16'h0000;
		if (regWr)
		begin
			unique case (regAddr)
				OFS_BIT_REVERSE_CONTROL: state_nxt.bitReverseControl = regWrData;
				OFS_ADDRESSING_MODE_CONTROL:
					state_nxt.addressingModeControl = regWrData;
				OFS_MODULO_START: state_nxt.moduloStart = regWrData;
				OFS_MODULO_END: state_nxt.moduloEnd = regWrData;
				default: state_nxt.rdData = 16'h0000;
			endcase
		end
		if (regRd)
		begin
			unique case (regAddr)
				OFS_BIT_REVERSE_CONTROL: state_nxt.rdData = state_r.bitReverseControl;
				OFS_ADDRESSING_MODE_CONTROL:
					state_nxt.rdData = state_r.addressingModeControl;
				OFS_MODULO_START: state_nxt.rdData = state_r.moduloStart;
				OFS_MODULO_END: state_nxt.rdData = state_r.moduloEnd;
				OFS_LAST_WRITE_EA: state_nxt.rdData = state_r.lastWriteEa;
				default: state_nxt.rdData = 16'h0000;
			endcase
		end
		state_nxt.rdResp = normalResp(rdReq, rdNext); // R1
		state_nxt.wrResp = normalResp(wrReq, wrNext); // R7
		if (revCond)
		begin
			// pointer plus reversed modifier; the increment is not used
			state_nxt.wrResp.reversed = 1'b1;
			state_nxt.wrResp.writeBack = 1'b1; // R13
			state_nxt.wrResp.wbValue = {revSum[15:1], 1'b0}; // R8 R9
			if (wrReq.mode == AM_PRE_INC)
			begin
				state_nxt.wrResp.ea = {revSum[15:1], 1'b0}; // R8 R9
			end
			else
			begin
				state_nxt.wrResp.ea = {wrReq.pointer[15:1], 1'b0}; // R2 R9
			end
		end
		if (wrReq.valid)
		begin
			state_nxt.lastWriteEa = state_nxt.wrResp.ea;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			state_r <= STATE_RESET;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign regRdData = state_r.rdData;
	assign wrResp = state_r.wrResp;
	assign rdResp = state_r.rdResp;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstN);

	read_no_reverse_a: assert property ( // R1
		rdResp.valid |-> !rdResp.reversed)
		else $error("read response marked reversed");

	reverse_cause_a: assert property ( // R3
		wrResp.reversed |-> $past(revCond) && wrResp.valid)
		else $error("reversed write without enabling conditions");

	reverse_taken_a: assert property ( // R11
		revCond |=> wrResp.reversed)
		else $error("enabled reversal not applied");

	byte_normal_a: assert property ( // R7
		wrResp.valid && $past(wrIsByte) |-> !wrResp.reversed)
		else $error("byte write was bit reversed");

	stack_excluded_a: assert property ( // R3
		(writePointerSelect == STACK_POINTER_NUM) |=> !wrResp.reversed)
		else $error("reversal with stack pointer selected");

	lsb_clear_a: assert property ( // R9
		wrResp.reversed |-> !wrResp.ea[0] && !wrResp.wbValue[0])
		else $error("reversed address has bit zero set");

	pre_sum_a: assert property ( // R8
		wrResp.reversed && ($past(wrMode) == AM_PRE_INC)
		|-> wrResp.ea == {$past(revSum[15:1]), 1'b0})
		else $error("pre-increment reversed address not pointer plus pivot");

	post_source_a: assert property ( // R2
		wrResp.reversed && ($past(wrMode) == AM_POST_INC)
		|-> wrResp.ea == {$past(wrPointer[15:1]), 1'b0})
		else $error("post-increment reversed address not the pointer");

	scaled_pivot_a: assert property ( // R6
		regWr && (regAddr == OFS_BIT_REVERSE_CONTROL)
		|=> scaledModifier == {$past(regWrData[14:0]), 1'b0})
		else $error("pivot not scaled to bytes");

	modulo_off_a: assert property ( // R10
		wrResp.reversed |-> wrResp.wbValue == {$past(revSum[15:1]), 1'b0})
		else $error("modulo correction touched a reversed write");

	offset_no_wb_a: assert property ( // R13
		rdResp.valid && ($past(rdMode) == AM_REG_OFFSET) |-> !rdResp.writeBack)
		else $error("register offset mode wrote back");

	ctrl_read_a: assert property ( // R5
		regRd && (regAddr == OFS_BIT_REVERSE_CONTROL) && !regWr
		|=> regRdData == $past(state_r.bitReverseControl))
		else $error("control register read back wrong");
endmodule : bit_reversed_write_agu
`default_nettype wire

// File: dv/cpu_stage_model.sv
// decode stage model issuing write and read address requests
`timescale 1ns/1ps
`default_nettype none
module cpu_stage_model (
	input wire logic sys_clk,
	output bitrev_agu_pkg::agu_req_t wrReq,
	output bitrev_agu_pkg::agu_req_t rdReq
);
	import bitrev_agu_pkg::*;

	initial
	begin
		wrReq = '0;
		rdReq = '0;
	end

	// one request for one cycle, then released with all fields inverted
	// callers keep buffers aligned to their size
	// no indirect read follows a control write at once
	task automatic issue(input logic toWrite, input logic isByte,
		input addr_mode_t mode, input logic [3:0] regNum,
		input logic [15:0] pointer, input logic [15:0] offset);
		agu_req_t r;
		r = '{1'b1, isByte, mode, regNum, pointer, offset};
		@(posedge sys_clk);
		if (toWrite)
			wrReq <= r;
		else
			rdReq <= r;
		@(posedge sys_clk);
		if (toWrite)
			wrReq <= ~r;
		else
			rdReq <= ~r;
	endtask : issue
endmodule : cpu_stage_model
`default_nettype wire

// File: dv/bit_reversed_write_agu_test.sv
// self-checking bench for the bit-reversed write address generator
`timescale 1ns/1ps
`default_nettype none
module bit_reversed_write_agu_test;
	import bitrev_agu_pkg::*;

	localparam logic T = 1'b1;
	localparam logic F = 1'b0;
	localparam logic [3:0] SEL = 4'h2;
	localparam logic [15:0] Z = 16'h0000;
	localparam logic [15:0] P = 16'h1008;
	localparam logic [15:0] PIV = 16'h0004;
	localparam logic [15:0] M = PIV << 1;
	localparam int LIMIT = 2000;

	logic sys_clk;
	logic arst_n;
	logic [7:0] regAddr;
	logic [15:0] regWrData;
	logic regWr;
	logic regRd;
	logic [15:0] regRdData;
	agu_req_t wrReq;
	agu_req_t rdReq;
	agu_resp_t wrResp;
	agu_resp_t rdResp;
	int numErrors;
	int samplesChecked;
	int cycles;
	logic [15:0] e;

	bit_reversed_write_agu bit_reversed_write_agu_inst (
		.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .wrReq(wrReq), .rdReq(rdReq),
		.wrResp(wrResp), .rdResp(rdResp));

	cpu_stage_model cpu_stage_model_inst (
		.sys_clk(sys_clk), .wrReq(wrReq), .rdReq(rdReq));

	always #25 sys_clk = ~sys_clk;

	task automatic summarize();
		$display("checks %0d mismatches %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			numErrors++;
			summarize();
		end
	end

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	function automatic logic [15:0] mir(input logic [15:0] v);
		mir = {<<{v}};
	endfunction : mir

	// add with carries running from the top bit down, word aligned
	function automatic logic [15:0] revadd(input logic [15:0] p,
		input logic [15:0] m);
		revadd = mir(mir(p) + mir(m)) & 16'hFFFE;
	endfunction : revadd

	task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		regWrData <= ~d;
	endtask : regWrite

	task automatic rdChk(input string what, input logic [7:0] a,
		input logic [15:0] exp);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1;
		chk(what, regRdData, exp);
		@(posedge sys_clk);
		#1;
		chk("read idle", regRdData, 16'h0000);
	endtask : rdChk

	task automatic send(input logic w, input logic b, input addr_mode_t m,
		input logic [3:0] n, input logic [15:0] p, input logic [15:0] o,
		input logic [15:0] ea, input logic [15:0] wb, input logic we,
		input logic rv);
		agu_resp_t r;
		cpu_stage_model_inst.issue(w, b, m, n, p, o);
		#1;
		r = w ? wrResp : rdResp;
		chk("valid", 16'(r.valid), 16'h0001);
		chk("ea", r.ea, ea);
		chk("writeBack", 16'(r.writeBack), 16'(we));
		chk("reversed", 16'(r.reversed), 16'(rv));
		if (we)
		begin
			chk("wbValue", r.wbValue, wb);
			chk("wbRegNum", 16'(r.wbRegNum), 16'(n));
		end
		@(posedge sys_clk);
		#1;
		r = w ? wrResp : rdResp;
		chk("idle", {14'h0000, r.valid, r.writeBack}, 16'h0000);
	endtask : send

	initial
	begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		numErrors = 0;
		samplesChecked = 0;
		cycles = 0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rdChk("control", OFS_BIT_REVERSE_CONTROL, BIT_REVERSE_CONTROL_RESET);
		rdChk("mode", OFS_ADDRESSING_MODE_CONTROL,
			ADDRESSING_MODE_CONTROL_RESET);
		rdChk("modulo end", OFS_MODULO_END, MODULO_END_RESET);
		rdChk("unmapped", 8'h20, 16'h0000);
		regWrite(OFS_LAST_WRITE_EA, 16'h1234);
		rdChk("last ea", OFS_LAST_WRITE_EA, LAST_WRITE_EA_RESET);
		$display("register test done");
		regWrite(OFS_BIT_REVERSE_CONTROL, 16'h8000 | PIV);
		regWrite(OFS_ADDRESSING_MODE_CONTROL, 16'h020F);
		rdChk("control", OFS_BIT_REVERSE_CONTROL, 16'h8004);
		e = revadd(P, M);
		send(T, F, AM_PRE_INC, SEL, P, Z, e, e, T, T);
		e = revadd(16'h1009, M);
		send(T, F, AM_POST_INC, SEL, 16'h1009, Z, P, e, T, T);
		rdChk("last ea", OFS_LAST_WRITE_EA, P);
		$display("reversed test done");
		send(T, T, AM_PRE_INC, SEL, P, Z, 16'h1009, 16'h1009, T, F);
		send(T, F, AM_POST_DEC, SEL, P, Z, P, 16'h1006, T, F);
		send(T, F, AM_REG_OFFSET, SEL, P, 16'h0010, 16'h1018, Z, F, F);
		send(T, F, AM_INDIRECT, SEL, P, Z, P, Z, F, F);
		send(F, F, AM_PRE_INC, SEL, P, Z, 16'h100A, 16'h100A, T, F);
		send(T, F, AM_PRE_INC, 4'h3, P, Z, 16'h100A, 16'h100A, T, F);
		regWrite(OFS_ADDRESSING_MODE_CONTROL, 16'h0F0F);
		send(T, F, AM_PRE_INC, 4'hF, P, Z, 16'h100A, 16'h100A, T, F);
		regWrite(OFS_ADDRESSING_MODE_CONTROL, 16'h020F);
		regWrite(OFS_BIT_REVERSE_CONTROL, PIV);
		send(T, F, AM_PRE_INC, SEL, P, Z, 16'h100A, 16'h100A, T, F);
		$display("fallback test done");
		regWrite(OFS_BIT_REVERSE_CONTROL, 16'h8000 | PIV);
		regWrite(OFS_MODULO_START, 16'h1000);
		regWrite(OFS_MODULO_END, 16'h1007);
		regWrite(OFS_ADDRESSING_MODE_CONTROL, 16'h8202);
		e = revadd(16'h1006, M);
		send(T, F, AM_POST_INC, SEL, 16'h1006, Z, 16'h1006, e, T, T);
		send(F, F, AM_POST_INC, SEL, 16'h1006, Z, 16'h1006, 16'h1000, T,
			F);
		$display("priority test done");
		summarize();
	end
endmodule : bit_reversed_write_agu_test
`default_nettype wire
